// *** verilog/bss_device.sv ***
// memory end of the burst-of-two separate-io port
`timescale 1ns/1ps
`default_nettype none
module bss_device
    import bss_pkg::*;
#(
    parameter int MEM_ADDR_W = BSS_ADDR_W,
    parameter int DLL_LOCK   = BSS_DLL_LOCK_CYCLES
) (
    input  wire logic i_clock,
    input  wire logic i_nrst,
    bss_if.device     link,
    output logic      o_dll_locked
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    localparam int SYNC_W = 7 + BSS_ADDR_W + BSS_DATA_W + BSS_LANES;
    localparam int LOCK_W = $clog2(DLL_LOCK + 1);

    logic [SYNC_W-1:0]     sync_meta;
    logic [SYNC_W-1:0]     sync_q;
    logic                  s_kp;
    logic                  s_kn;
    logic                  s_op;
    logic                  s_on;
    logic                  s_load_n;
    logic                  s_rw;
    logic [BSS_ADDR_W-1:0] s_addr;
    logic [BSS_DATA_W-1:0] s_wbus;
    logic [BSS_LANES-1:0]  s_mask_n;
    logic                  s_dll_n;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_meta <= '0;
            sync_q    <= '0;
        end else begin
            sync_meta <= {link.input_timing_ref_p, link.input_timing_ref_n, link.output_timing_ref_p,
                          link.output_timing_ref_n, link.load_request_n, link.read_write_sel,
                          link.addr_in, link.write_bus, link.byte_write_mask_n, link.dll_bypass_n};
            sync_q    <= sync_meta;
        end
    end

    assign {s_kp, s_kn, s_op, s_on, s_load_n, s_rw, s_addr, s_wbus, s_mask_n, s_dll_n} = sync_q;

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    logic use_k;
    logic oc_p;
    logic oc_n;
    logic prev_kp;
    logic prev_kn;
    logic prev_op;
    logic prev_on;
    logic k_rise;
    logic kn_rise;
    logic op_rise;
    logic on_rise;

    assign use_k = s_op & s_on;
    assign oc_p  = use_k ? s_kp : s_op;
    assign oc_n  = use_k ? s_kn : s_on;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_kp <= 1'b0;
            prev_kn <= 1'b0;
            prev_op <= 1'b0;
            prev_on <= 1'b0;
        end else begin
            prev_kp <= s_kp;
            prev_kn <= s_kn;
            prev_op <= oc_p;
            prev_on <= oc_n;
        end
    end

    assign k_rise  = s_kp & ~prev_kp;
    assign kn_rise = s_kn & ~prev_kn;
    assign op_rise = oc_p & ~prev_op;
    assign on_rise = oc_n & ~prev_on;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic cmd_rd;
    logic cmd_wr;

    assign cmd_rd = k_rise & ~s_load_n & s_rw;
    assign cmd_wr = k_rise & ~s_load_n & ~s_rw;

    function automatic logic [BSS_DATA_W-1:0] merge(input logic [BSS_DATA_W-1:0] old_w,
                                                    input logic [BSS_DATA_W-1:0] new_w,
                                                    input logic [BSS_LANES-1:0]  mask_n);
        logic [BSS_DATA_W-1:0] res;
        res = old_w;
        for (int l = 0; l < BSS_LANES; l++) begin
            if (!mask_n[l]) begin
                res[l*BSS_BYTE_W +: BSS_BYTE_W] = new_w[l*BSS_BYTE_W +: BSS_BYTE_W];
            end
        end
        return res;
    endfunction

    // ----------------------------------------
    // late write buffer
    // ----------------------------------------
    bss_wstate_t           wstate;
    logic [MEM_ADDR_W-1:0] wb_addr;
    logic [BSS_DATA_W-1:0] wb_d0;
    logic [BSS_LANES-1:0]  wb_m0;
    logic [BSS_DATA_W-1:0] mem [0:(2**(MEM_ADDR_W+1))-1];
    logic [MEM_ADDR_W-1:0] cur_addr;
    logic                  commit;

    assign cur_addr = s_addr[MEM_ADDR_W-1:0];
    assign commit   = kn_rise & (wstate == BSS_W_WORD1);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wstate  <= BSS_W_IDLE;
            wb_addr <= '0;
            wb_d0   <= '0;
            wb_m0   <= '0;
        end else begin
            unique case (wstate)
                BSS_W_IDLE: begin
                    if (cmd_wr) begin
                        wstate  <= BSS_W_WORD0;
                        wb_addr <= cur_addr;
                    end
                end
                BSS_W_WORD0: begin
                    if (k_rise) begin
                        wstate <= BSS_W_WORD1;
                        wb_d0  <= s_wbus;
                        wb_m0  <= s_mask_n;
                    end
                end
                BSS_W_WORD1: begin
                    if (kn_rise) begin
                        wstate <= BSS_W_IDLE;
                    end
                end
                default: wstate <= BSS_W_IDLE;
            endcase
        end
    end

    // self-timed array update once both words are in
    always_ff @(posedge i_clock) begin
        if (commit) begin
            mem[{wb_addr, 1'b0}] <= merge(mem[{wb_addr, 1'b0}], wb_d0, wb_m0);
            mem[{wb_addr, 1'b1}] <= merge(mem[{wb_addr, 1'b1}], s_wbus, s_mask_n);
        end
    end

    // ----------------------------------------
    // read slots
    // ----------------------------------------
    logic                  rd_hit;
    logic [BSS_DATA_W-1:0] rd_d0;
    logic                  slot_sel;
    logic                  slot_busy [0:1];
    logic                  slot_hit [0:1];
    logic [BSS_DATA_W-1:0] slot_d0 [0:1];
    logic [BSS_DATA_W-1:0] slot_d1 [0:1];
    logic [1:0]            slot_cn [0:1];
    logic [1:0]            slot_cp [0:1];
    logic [1:0]            slot_tn [0:1];
    logic [1:0]            slot_tp [0:1];
    logic [1:0]            drive0;
    logic [1:0]            drive1;
    logic                  dll_off;

    assign rd_hit = (wstate == BSS_W_WORD0) & (wb_addr == cur_addr);
    assign rd_d0  = rd_hit ? merge(mem[{cur_addr, 1'b0}], s_wbus, s_mask_n) : mem[{cur_addr, 1'b0}];

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            slot_sel <= 1'b0;
        end else if (cmd_rd) begin
            slot_sel <= ~slot_sel;
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_slot
            assign drive0[i] = slot_busy[i] & on_rise & (slot_cn[i] + 2'h1 == slot_tn[i]);
            assign drive1[i] = slot_busy[i] & op_rise & (slot_cp[i] + 2'h1 == slot_tp[i]);

            always_ff @(posedge i_clock or negedge i_nrst) begin
                if (!i_nrst) begin
                    slot_busy[i] <= 1'b0;
                    slot_hit[i]  <= 1'b0;
                    slot_d0[i]   <= '0;
                    slot_d1[i]   <= '0;
                    slot_cn[i]   <= 2'h0;
                    slot_cp[i]   <= 2'h0;
                    slot_tn[i]   <= 2'h0;
                    slot_tp[i]   <= 2'h0;
                end else if (cmd_rd && (slot_sel == 1'(i))) begin
                    slot_busy[i] <= 1'b1;
                    slot_hit[i]  <= rd_hit;
                    slot_d0[i]   <= rd_d0;
                    slot_d1[i]   <= mem[{cur_addr, 1'b1}];
                    slot_cn[i]   <= 2'h0;
                    slot_cp[i]   <= op_rise ? 2'h1 : 2'h0;
                    slot_tn[i]   <= dll_off ? BSS_RD_N_EDGE_OFF : BSS_RD_N_EDGE_DLL;
                    slot_tp[i]   <= dll_off ? BSS_RD_P_EDGE_OFF : BSS_RD_P_EDGE_DLL;
                end else if (slot_busy[i]) begin
                    if (on_rise) begin
                        slot_cn[i] <= slot_cn[i] + 2'h1;
                    end
                    if (op_rise) begin
                        slot_cp[i] <= slot_cp[i] + 2'h1;
                    end
                    if (commit && slot_hit[i]) begin
                        slot_d1[i]  <= merge(slot_d1[i], s_wbus, s_mask_n);
                        slot_hit[i] <= 1'b0;
                    end
                    if (drive1[i]) begin
                        slot_busy[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // output register and echo strobes
    // ----------------------------------------
    logic second_out;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            link.output_bus    <= '0;
            link.output_bus_oe <= 1'b0;
            second_out         <= 1'b0;
        end else if (|drive0) begin
            link.output_bus    <= drive0[0] ? slot_d0[0] : slot_d0[1];
            link.output_bus_oe <= 1'b1;
            second_out         <= 1'b0;
        end else if (|drive1) begin
            link.output_bus    <= drive1[0] ? slot_d1[0] : slot_d1[1];
            second_out         <= 1'b1;
        end else if (on_rise && second_out) begin
            link.output_bus_oe <= 1'b0;
            second_out         <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            link.echo_strobe_p <= 1'b0;
            link.echo_strobe_n <= 1'b0;
        end else begin
            link.echo_strobe_p <= oc_p;
            link.echo_strobe_n <= oc_n;
        end
    end

    // ----------------------------------------
    // delay-locked loop model
    // ----------------------------------------
    logic [LOCK_W-1:0] lock_cnt;

    assign dll_off = ~s_dll_n;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            lock_cnt     <= '0;
            o_dll_locked <= 1'b0;
        end else if (dll_off) begin
            lock_cnt     <= '0;
            o_dll_locked <= 1'b0;
        end else if (lock_cnt == LOCK_W'(DLL_LOCK)) begin
            o_dll_locked <= 1'b1;
        end else begin
            lock_cnt <= lock_cnt + LOCK_W'(1);
        end
    end
endmodule
`default_nettype wire

// *** verilog/bss_pkg.sv ***
// shared constants of the burst-of-two separate-io memory port
`default_nettype none
package bss_pkg;
    // ----------------------------------------
    // organisation
    // ----------------------------------------
    localparam bit BSS_ORG_X36 = 1'b1;
    localparam int BSS_DATA_W  = BSS_ORG_X36 ? 36 : 18;
    localparam int BSS_ADDR_W  = BSS_ORG_X36 ? 20 : 21;
    localparam int BSS_BYTE_W  = 9;
    localparam int BSS_LANES   = BSS_DATA_W / BSS_BYTE_W;
    localparam int BSS_BURST   = 2;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int BSS_CLK_NS         = 8;
    localparam int BSS_LINK_PERIOD_NS = 160;
    localparam int BSS_LINK_PERIOD    = BSS_LINK_PERIOD_NS / BSS_CLK_NS;
    localparam int BSS_LINK_HALF      = BSS_LINK_PERIOD / 2;
    localparam int BSS_CMD_PHASE      = (BSS_LINK_PERIOD * 3) / 4;
    localparam int BSS_WORD1_PHASE    = BSS_LINK_PERIOD / 4;
    localparam int BSS_DLL_LOCK_CYCLES = 2048;
    localparam logic [1:0] BSS_RD_N_EDGE_DLL = 2'h2;
    localparam logic [1:0] BSS_RD_P_EDGE_DLL = 2'h3;
    localparam logic [1:0] BSS_RD_N_EDGE_OFF = 2'h1;
    localparam logic [1:0] BSS_RD_P_EDGE_OFF = 2'h2;
    // ----------------------------------------
    // write buffer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        BSS_W_IDLE  = 2'b00,
        BSS_W_WORD0 = 2'b01,
        BSS_W_WORD1 = 2'b10
    } bss_wstate_t;
endpackage
`default_nettype wire

// *** verilog/bss_if.sv ***
// pins between memory controller and memory port
`timescale 1ns/1ps
`default_nettype none
interface bss_if;
    import bss_pkg::*;
    logic                  input_timing_ref_p;
    logic                  input_timing_ref_n;
    logic                  output_timing_ref_p;
    logic                  output_timing_ref_n;
    logic                  load_request_n;
    logic                  read_write_sel;
    logic [BSS_ADDR_W-1:0] addr_in;
    logic [BSS_DATA_W-1:0] write_bus;
    logic [BSS_LANES-1:0]  byte_write_mask_n;
    logic                  dll_bypass_n;
    logic [BSS_DATA_W-1:0] output_bus;
    logic                  output_bus_oe;
    logic                  echo_strobe_p;
    logic                  echo_strobe_n;

    modport device (
        input  input_timing_ref_p, input_timing_ref_n, output_timing_ref_p, output_timing_ref_n,
        input  load_request_n, read_write_sel, addr_in, write_bus, byte_write_mask_n, dll_bypass_n,
        output output_bus, output_bus_oe, echo_strobe_p, echo_strobe_n
    );
    modport controller (
        output input_timing_ref_p, input_timing_ref_n, output_timing_ref_p, output_timing_ref_n,
        output load_request_n, read_write_sel, addr_in, write_bus, byte_write_mask_n, dll_bypass_n,
        input  output_bus, output_bus_oe, echo_strobe_p, echo_strobe_n
    );
endinterface
`default_nettype wire

// *** verilog/bss_controller.sv ***
// controller end of the burst-of-two separate-io port
`timescale 1ns/1ps
`default_nettype none
module bss_controller
    import bss_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_nrst,
    bss_if.controller                  link,
    input  wire logic                  i_req_valid,
    input  wire logic                  i_req_write,
    input  wire logic [BSS_ADDR_W-1:0] i_req_addr,
    input  wire logic [BSS_DATA_W-1:0] i_wdata0,
    input  wire logic [BSS_DATA_W-1:0] i_wdata1,
    input  wire logic [BSS_LANES-1:0]  i_wmask0_n,
    input  wire logic [BSS_LANES-1:0]  i_wmask1_n,
    output logic                       o_req_ready,
    input  wire logic                  i_dll_enable,
    input  wire logic                  i_use_out_clk,
    output logic [BSS_DATA_W-1:0]      o_rdata0,
    output logic [BSS_DATA_W-1:0]      o_rdata1,
    output logic                       o_rdata_valid
);
    // ----------------------------------------
    // link clock divider
    // ----------------------------------------
    localparam int DIV_W = $clog2(BSS_LINK_PERIOD);

    logic [DIV_W-1:0] div;
    logic             ref_hi;

    assign ref_hi = (div < DIV_W'(BSS_LINK_HALF));

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            div <= '0;
        end else if (div == DIV_W'(BSS_LINK_PERIOD - 1)) begin
            div <= '0;
        end else begin
            div <= div + DIV_W'(1);
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            link.input_timing_ref_p  <= 1'b0;
            link.input_timing_ref_n  <= 1'b1;
            link.output_timing_ref_p <= 1'b1;
            link.output_timing_ref_n <= 1'b1;
            link.dll_bypass_n        <= 1'b0;
        end else begin
            link.input_timing_ref_p  <= ref_hi;
            link.input_timing_ref_n  <= ~ref_hi;
            link.output_timing_ref_p <= i_use_out_clk ? ref_hi : 1'b1;
            link.output_timing_ref_n <= i_use_out_clk ? ~ref_hi : 1'b1;
            link.dll_bypass_n        <= i_dll_enable;
        end
    end

    // ----------------------------------------
    // command slots, read and write alternate
    // ----------------------------------------
    logic                  cmd_point;
    logic                  word1_point;
    logic                  read_slot;
    logic                  take;
    logic                  wpend0;
    logic                  wpend1;
    logic [BSS_DATA_W-1:0] wd0;
    logic [BSS_DATA_W-1:0] wd1;
    logic [BSS_LANES-1:0]  wm0;
    logic [BSS_LANES-1:0]  wm1;

    assign cmd_point   = (div == DIV_W'(BSS_CMD_PHASE));
    assign word1_point = (div == DIV_W'(BSS_WORD1_PHASE));
    assign o_req_ready = cmd_point & (i_req_write != read_slot);
    assign take        = i_req_valid & o_req_ready;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            read_slot           <= 1'b1;
            link.load_request_n <= 1'b1;
            link.read_write_sel <= 1'b1;
            link.addr_in        <= '0;
        end else if (cmd_point) begin
            read_slot           <= ~read_slot;
            link.load_request_n <= ~take;
            link.read_write_sel <= ~i_req_write;
            link.addr_in        <= i_req_addr;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wpend0                 <= 1'b0;
            wpend1                 <= 1'b0;
            wd0                    <= '0;
            wd1                    <= '0;
            wm0                    <= '1;
            wm1                    <= '1;
            link.write_bus         <= '0;
            link.byte_write_mask_n <= '1;
        end else if (cmd_point) begin
            wpend0 <= take & i_req_write;
            wpend1 <= wpend0;
            if (take && i_req_write) begin
                wd0 <= i_wdata0;
                wd1 <= i_wdata1;
                wm0 <= i_wmask0_n;
                wm1 <= i_wmask1_n;
            end
            if (wpend0) begin
                link.write_bus         <= wd0;
                link.byte_write_mask_n <= wm0;
            end
        end else if (word1_point && wpend1) begin
            link.write_bus         <= wd1;
            link.byte_write_mask_n <= wm1;
            wpend1                 <= 1'b0;
        end
    end

    // ----------------------------------------
    // read capture on echo strobes
    // ----------------------------------------
    localparam int RS_W = BSS_DATA_W + 3;

    logic [RS_W-1:0]       rs_meta;
    logic [RS_W-1:0]       rs_q;
    logic [BSS_DATA_W-1:0] r_bus;
    logic                  r_oe;
    logic                  r_ep;
    logic                  r_en;
    logic                  prev_ep;
    logic                  prev_en;
    logic                  got0;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rs_meta <= '0;
            rs_q    <= '0;
            prev_ep <= 1'b0;
            prev_en <= 1'b0;
        end else begin
            rs_meta <= {link.output_bus, link.output_bus_oe, link.echo_strobe_p, link.echo_strobe_n};
            rs_q    <= rs_meta;
            prev_ep <= r_ep;
            prev_en <= r_en;
        end
    end

    assign {r_bus, r_oe, r_ep, r_en} = rs_q;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata0      <= '0;
            o_rdata1      <= '0;
            o_rdata_valid <= 1'b0;
            got0          <= 1'b0;
        end else begin
            o_rdata_valid <= 1'b0;
            if (r_en && !prev_en && r_oe && !got0) begin
                o_rdata0 <= r_bus;
                got0     <= 1'b1;
            end else if (r_ep && !prev_ep && r_oe && got0) begin
                o_rdata1      <= r_bus;
                o_rdata_valid <= 1'b1;
                got0          <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/bss_placeholder_none.sv ***
// intentionally empty design unit list end
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/bss_assertions.sv ***
// pin-level checks of the memory port link
`timescale 1ns/1ps
`default_nettype none
module bss_assertions
    import bss_pkg::*;
(
    input wire logic                  i_clock,
    input wire logic                  i_nrst,
    input wire logic                  input_timing_ref_p,
    input wire logic                  input_timing_ref_n,
    input wire logic                  load_request_n,
    input wire logic                  read_write_sel,
    input wire logic [BSS_ADDR_W-1:0] addr_in,
    input wire logic [BSS_DATA_W-1:0] write_bus,
    input wire logic [BSS_DATA_W-1:0] output_bus,
    input wire logic                  output_bus_oe,
    input wire logic                  echo_strobe_p,
    input wire logic                  echo_strobe_n
);
    // ----------------------------------------
    // echo idle counter and properties
    // ----------------------------------------
    logic [4:0] echo_idle;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            echo_idle <= 5'h00;
        end else if ($changed(echo_strobe_p)) begin
            echo_idle <= 5'h00;
        end else if (echo_idle != 5'h1f) begin
            echo_idle <= echo_idle + 5'h01;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    sequence s_cmd;
        $rose(input_timing_ref_p) && !load_request_n;
    endsequence
    sequence s_word0;
        $rose(output_bus_oe);
    endsequence
    a_refs_complement: assert property (input_timing_ref_p != input_timing_ref_n)
        else $error("input refs not complementary");
    a_ref_period: assert property ($rose(input_timing_ref_p) |-> ##20 $rose(input_timing_ref_p))
        else $error("input ref period wrong");
    a_cmd_at_rise: assert property ($changed(addr_in) || $changed(load_request_n) |-> !input_timing_ref_p)
        else $error("command moved near ref rise");
    a_wdata_stable: assert property ($changed(write_bus) |-> $stable(input_timing_ref_p))
        else $error("write data moved at ref edge");
    a_read_latency: assert property (s_cmd ##0 read_write_sel |-> ##[8:36] s_word0)
        else $error("read data late");
    a_word0_hold: assert property (s_word0 |=> $stable(output_bus) [*8])
        else $error("first read word not held");
    a_echo_aligned: assert property (s_word0 |-> $rose(echo_strobe_n))
        else $error("echo not aligned with data");
    a_echo_running: assert property (echo_idle < 5'h18)
        else $error("echo strobe stopped");
endmodule
`default_nettype wire

// *** tb/burst2_sio_sram_port_tb_top.sv ***
// self-checking bench joining controller and memory ends
`timescale 1ns/1ps
`default_nettype none
module burst2_sio_sram_port_tb_top
    import bss_pkg::*;
;
    // ----------------------------------------
    // stimulus, model and checks
    // ----------------------------------------
    logic                    i_clock = 1'b0;
    logic                    i_nrst;
    logic                    req_valid, req_write, req_ready, dll_enable, use_out_clk, dll_locked, rdata_valid;
    logic [BSS_ADDR_W-1:0]   req_addr;
    logic [BSS_DATA_W-1:0]   rdata0, rdata1;
    logic [2*BSS_DATA_W-1:0] wd;
    logic [2*BSS_LANES-1:0]  wm;
    logic [2*BSS_DATA_W-1:0] mem [8];
    bit                      known [8];
    logic [31:0]             r1, r2;
    int                      seed = 41832;
    int                      mismatches = 0;
    int                      n_checks = 0;
    int                      cycles = 0;
    bss_if link_if ();
    bss_device #(.MEM_ADDR_W(6), .DLL_LOCK(8)) i_bss_device (.i_clock(i_clock), .i_nrst(i_nrst), .link(link_if),
        .o_dll_locked(dll_locked));
    bss_controller i_bss_controller (.i_clock(i_clock), .i_nrst(i_nrst), .link(link_if), .i_req_valid(req_valid),
        .i_req_write(req_write), .i_req_addr(req_addr), .i_wdata0(wd[35:0]), .i_wdata1(wd[71:36]),
        .i_wmask0_n(wm[3:0]), .i_wmask1_n(wm[7:4]), .o_req_ready(req_ready), .i_dll_enable(dll_enable),
        .i_use_out_clk(use_out_clk), .o_rdata0(rdata0), .o_rdata1(rdata1), .o_rdata_valid(rdata_valid));
    bss_assertions i_bss_assertions (.i_clock(i_clock), .i_nrst(i_nrst),
        .input_timing_ref_p(link_if.input_timing_ref_p), .input_timing_ref_n(link_if.input_timing_ref_n),
        .load_request_n(link_if.load_request_n), .read_write_sel(link_if.read_write_sel),
        .addr_in(link_if.addr_in), .write_bus(link_if.write_bus), .output_bus(link_if.output_bus),
        .output_bus_oe(link_if.output_bus_oe), .echo_strobe_p(link_if.echo_strobe_p),
        .echo_strobe_n(link_if.echo_strobe_n));
    always #4 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches = mismatches + 1;
            test_done();
        end
    end
    function automatic logic [2*BSS_DATA_W-1:0] merge(input logic [2*BSS_DATA_W-1:0] old,
        input logic [2*BSS_DATA_W-1:0] nd, input logic [2*BSS_LANES-1:0] m);
        logic [2*BSS_DATA_W-1:0] res;
        res = old;
        for (int j = 0; j < 2*BSS_LANES; j++) begin
            if (!m[j]) res[j*BSS_BYTE_W +: BSS_BYTE_W] = nd[j*BSS_BYTE_W +: BSS_BYTE_W];
        end
        return res;
    endfunction
    task automatic check(input logic [BSS_DATA_W-1:0] got, input logic [BSS_DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp || $isunknown(exp)) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic request(input logic wr, input logic [2:0] a);
        int k;
        k = 0;
        @(negedge i_clock);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = BSS_ADDR_W'(a);
        #1;
        while (req_ready !== 1'b1 && k < 100) begin
            @(negedge i_clock);
            #1;
            k++;
        end
        if (k == 100) mismatches++;
        @(posedge i_clock);
        @(negedge i_clock);
        req_valid = 1'b0;
    endtask
    task automatic read_check(input logic [2:0] a);
        int k;
        k = 0;
        request(1'b0, a);
        while (rdata_valid !== 1'b1 && k < 300) begin
            @(negedge i_clock);
            k++;
        end
        if (k == 300) mismatches++;
        check(rdata0, mem[a][35:0]);
        check(rdata1, mem[a][71:36]);
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        i_nrst = 1'b0;
        {req_valid, req_write, req_addr, wd, wm} = '0;
        dll_enable = 1'b1;
        use_out_clk = 1'b1;
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        i_nrst = 1'b1;
        for (int mode = 0; mode < 4; mode++) begin
            @(negedge i_clock);
            dll_enable = (mode != 2);
            use_out_clk = (mode != 1);
            repeat (80) @(negedge i_clock);
            check({35'h0, dll_locked}, {35'h0, dll_enable});
            for (int i = 0; i < 6; i++) begin
                r1 = $random(seed);
                r2 = $random(seed);
                wd = {r1[7:0], r2, $random(seed)};
                wm = known[r1[10:8]] ? r2[7:0] : 8'h00;
                if (i == 5 && known[r1[10:8]]) wm = 8'hff;
                mem[r1[10:8]] = merge(mem[r1[10:8]], wd, wm);
                known[r1[10:8]] = 1'b1;
                request(1'b1, r1[10:8]);
                read_check(r1[10:8]);
                if (known[r2[13:11]]) read_check(r2[13:11]);
            end
        end
        test_done();
    end
endmodule
`default_nettype wire
